// File: design/ebi_regs.svh
// Purpose: Constants for the external and internal bus interface.
// Assumes: One 100 MHz clock.
// Notes:   Widths, address windows and timing counts only.
`ifndef EBI_REGS_SVH
`define EBI_REGS_SVH
`define EBI_ADDR_W        26
`define EBI_DATA_W        16
`define EBI_PADDR_W       16
`define EBI_IO_LIMIT      26'h0000400
`define EBI_EXT_BASE      26'h000F800
`define EBI_PERIPH_BASE   26'h3FF0000
`define EBI_CLK_NS        10
`define EBI_STROBE_NS     30
`define EBI_STROBE_CYC    ((`EBI_STROBE_NS + `EBI_CLK_NS - 1) / `EBI_CLK_NS)
`define EBI_SAMPLE_CYC    2
`endif

// File: design/ebi_pkg.sv
// Purpose: Types shared by the bus interface files.
// Assumes: Constants come from ebi_regs.svh.
// Notes:   Requests and answers travel as packed structs.
`include "ebi_regs.svh"
package ebi_pkg;
   typedef struct packed {
      logic                    valid;
      logic                    write;
      logic                    word;
      logic                    io;
      logic [`EBI_ADDR_W-1:0]  addr;
      logic [`EBI_DATA_W-1:0]  wdata;
   } ebi_req_t;
   typedef struct packed {
      logic                    done;
      logic [`EBI_DATA_W-1:0]  rdata;
   } ebi_rsp_t;
   typedef enum logic [4:0] {
      EBI_IDLE   = 5'h01,
      EBI_ADDR   = 5'h02,
      EBI_STROBE = 5'h04,
      EBI_NEXT   = 5'h08,
      EBI_DONE   = 5'h10
   } ebi_state_t;
endpackage

// File: design/ebi_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Input is asynchronous to clk.
// Notes:   Output changes only when the second and third stages agree.
`timescale 1ns/100ps
module ebi_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic din,
   output logic      dout
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule

// File: design/ebi_bus_unit.sv
// Purpose: Bus unit between core, internal buses and external memory bus.
// Assumes: Core holds its request until done; partner answers within the strobe.
// Notes:   Peripheral requests complete in one select cycle; external requests run on the external bus and are also mirrored on the wide bus.
`timescale 1ns/100ps
`include "ebi_regs.svh"
module ebi_bus_unit
   import ebi_pkg::*;
#(
   parameter int ADDR_W = `EBI_ADDR_W,
   parameter int DATA_W = `EBI_DATA_W
) (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire ebi_req_t           core_req,
   output ebi_rsp_t                core_rsp,
   output logic [ADDR_W-1:0]       ext_addr,
   output logic [DATA_W-1:0]       ext_data_o,
   output logic                    ext_data_oe_b,
   input  wire logic [DATA_W-1:0]  ext_data_i,
   output logic                    ext_wr_dir,
   output logic                    ext_rd_b,
   output logic                    ext_wr_b,
   output logic                    ext_ble_b,
   output logic                    ext_bhe_b,
   input  wire logic               narrow_bus_size_n,
   output ebi_req_t                wide_internal_memory_bus,
   input  wire logic [DATA_W-1:0]  wide_rdata,
   output logic [`EBI_PADDR_W-1:0] periph_addr,
   output logic [DATA_W-1:0]       periph_wdata,
   output logic                    periph_sel,
   output logic                    periph_write,
   input  wire logic [DATA_W-1:0]  periph_rdata
);
   ebi_state_t        st_r;
   ebi_state_t        st_nxt;
   logic [3:0]        cnt_r;
   logic              split_r;
   logic              odd_r;
   logic [7:0]        lo_byte_r;
   logic              narrow_s;
   logic              in_io_legacy;
   logic              in_periph;
   logic              new_req;
   logic              sample_win;
   logic              strobe_end;
   logic [DATA_W-1:0] rd_word_r;
   logic              take_ext;
   logic              take_periph;
   logic              split_hit;
   logic              strobe_nxt;
   logic              drive_nxt;
   logic              first_ble_b;
   logic              first_bhe_b;
   logic [ADDR_W-1:0] odd_addr;
   logic [DATA_W-1:0] odd_wdata;
   logic [DATA_W-1:0] merged_rdata;

   ebi_sync #(.RST_VAL(1'b1)) u_bs_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .din   (narrow_bus_size_n),
      .dout  (narrow_s)
   );

   // Extended registers sit in a window above the legacy I/O space.
   assign in_io_legacy = core_req.io && (core_req.addr < `EBI_IO_LIMIT);
   assign in_periph    = core_req.io && (core_req.addr >= `EBI_EXT_BASE) ||
                         (!core_req.io && core_req.addr >= `EBI_PERIPH_BASE);
   // A held request is not taken again while its peripheral select or done pulse stands.
   assign new_req      = core_req.valid && !core_rsp.done && !periph_sel && (st_r == EBI_IDLE);
   assign sample_win   = (st_r == EBI_STROBE) && (cnt_r == 4'(`EBI_SAMPLE_CYC));
   assign strobe_end   = (st_r == EBI_STROBE) && (cnt_r == 4'(`EBI_STROBE_CYC));
   assign take_ext     = new_req && !in_periph && !in_io_legacy;
   assign take_periph  = new_req && (in_periph || in_io_legacy);
   assign split_hit    = sample_win && !narrow_s && core_req.word && !odd_r;
   assign strobe_nxt   = (st_nxt == EBI_STROBE);
   assign drive_nxt    = (st_nxt == EBI_STROBE || st_nxt == EBI_NEXT) && core_req.write;
   assign first_ble_b  = core_req.addr[0];
   assign first_bhe_b  = !(core_req.word || core_req.addr[0]);
   assign odd_addr     = {ext_addr[ADDR_W-1:1], 1'b1};
   assign odd_wdata    = {core_req.wdata[15:8], core_req.wdata[15:8]};
   assign merged_rdata = split_r ? {rd_word_r[15:8], lo_byte_r} : rd_word_r;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         EBI_IDLE:   if (take_ext) begin
            st_nxt = EBI_ADDR;
         end
         EBI_ADDR:   st_nxt = EBI_STROBE;
         EBI_STROBE: if (strobe_end) begin
            st_nxt = (split_r && !odd_r) ? EBI_NEXT : EBI_DONE;
         end
         EBI_NEXT:   st_nxt = EBI_STROBE;
         EBI_DONE:   st_nxt = EBI_IDLE;
         default:    st_nxt = EBI_IDLE;
      endcase
   end

   // All state is held in flip-flops with no dynamic storage or refresh.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r    <= EBI_IDLE;
         cnt_r   <= 4'h0;
         split_r <= 1'b0;
         odd_r   <= 1'b0;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= (st_r == EBI_STROBE && !strobe_end) ? cnt_r + 4'h1 : 4'h1;
         if (st_r == EBI_IDLE) begin
            split_r <= 1'b0;
            odd_r   <= 1'b0;
         end else if (split_hit) begin
            split_r <= 1'b1;
         end else if (st_r == EBI_NEXT) begin
            odd_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_addr   <= '0;
         ext_data_o <= '0;
         ext_wr_dir <= 1'b0;
         ext_ble_b  <= 1'b1;
         ext_bhe_b  <= 1'b1;
      end else if (take_ext) begin
         ext_addr   <= core_req.addr;
         ext_wr_dir <= core_req.write;
         ext_data_o <= core_req.wdata;
         ext_ble_b  <= first_ble_b;
         ext_bhe_b  <= first_bhe_b;
      end else if (st_r == EBI_NEXT) begin
         ext_addr   <= odd_addr;
         ext_data_o <= odd_wdata;
         ext_ble_b  <= 1'b1;
         ext_bhe_b  <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_rd_b      <= 1'b1;
         ext_wr_b      <= 1'b1;
         ext_data_oe_b <= 1'b1;
      end else begin
         ext_rd_b      <= !(strobe_nxt && !core_req.write);
         ext_wr_b      <= !(strobe_nxt && core_req.write);
         ext_data_oe_b <= !drive_nxt;
      end
   end

   // Read data is taken in the last strobe cycle, while the partner still drives it.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rd_word_r <= '0;
         lo_byte_r <= 8'h00;
      end else if (strobe_end) begin
         rd_word_r <= ext_data_i;
         if (!odd_r) begin
            lo_byte_r <= ext_data_i[7:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wide_internal_memory_bus <= '0;
      end else begin
         wide_internal_memory_bus       <= core_req;
         wide_internal_memory_bus.valid <= take_ext;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         periph_addr  <= '0;
         periph_wdata <= '0;
         periph_sel   <= 1'b0;
         periph_write <= 1'b0;
      end else begin
         periph_sel   <= take_periph;
         periph_addr  <= core_req.addr[`EBI_PADDR_W-1:0];
         periph_wdata <= core_req.wdata;
         periph_write <= core_req.write;
      end
   end

   // The done pulse lasts one cycle and carries the peripheral read data or the merged external read data.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_rsp <= '0;
      end else begin
         core_rsp.done <= 1'b0;
         if (periph_sel) begin
            core_rsp.done  <= 1'b1;
            core_rsp.rdata <= periph_rdata;
         end else if (st_r == EBI_DONE) begin
            core_rsp.done  <= 1'b1;
            core_rsp.rdata <= merged_rdata;
         end
      end
   end

   logic unused_wide;
   assign unused_wide = ^wide_rdata;
endmodule

// File: bench/ebi_bus_unit_checker.sv
// Purpose: Port assertions for the bus unit.
// Assumes: Core requests are held until done.
// Notes:   Bound to every bus unit.
`timescale 1ns/100ps
`include "ebi_regs.svh"
module ebi_chk
   import ebi_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   rst_b,
   input wire ebi_req_t               core_req,
   input wire logic [`EBI_ADDR_W-1:0] ext_addr,
   input wire logic                   ext_data_oe_b,
   input wire logic                   ext_wr_dir,
   input wire logic                   ext_rd_b,
   input wire logic                   ext_wr_b,
   input wire logic                   ext_ble_b,
   input wire logic                   ext_bhe_b,
   input wire ebi_req_t               wide_internal_memory_bus,
   input wire logic [15:0]            periph_addr,
   input wire logic                   periph_sel,
   input wire logic                   narrow_bus_size_n
);
   logic [3:0] narrow_low_cnt_r;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Counts how long the narrow bus-size input has been held low, saturating.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         narrow_low_cnt_r <= 4'h0;
      end else if (narrow_bus_size_n) begin
         narrow_low_cnt_r <= 4'h0;
      end else if (narrow_low_cnt_r != 4'hF) begin
         narrow_low_cnt_r <= narrow_low_cnt_r + 4'h1;
      end
   end
   property p_dir; !ext_rd_b |-> !ext_wr_dir && ext_data_oe_b; endproperty
   a_dir: assert property (p_dir) else $error("read strobe with write direction");
   property p_wdir; !ext_wr_b |-> ext_wr_dir && !ext_data_oe_b; endproperty
   a_wdir: assert property (p_wdir) else $error("write strobe without drive");
   property p_excl; !(!ext_rd_b && !ext_wr_b); endproperty
   a_excl: assert property (p_excl) else $error("both strobes low");
   property p_rdw; $fell(ext_rd_b) |-> !ext_rd_b[*3] ##1 ext_rd_b; endproperty
   a_rdw: assert property (p_rdw) else $error("read strobe width wrong");
   property p_hold; !ext_rd_b && !$fell(ext_rd_b) |-> $stable(ext_addr); endproperty
   a_hold: assert property (p_hold) else $error("address moved in cycle");
   property p_addr; !ext_ble_b && (!ext_rd_b || !ext_wr_b) |-> ext_addr == core_req.addr; endproperty
   a_addr: assert property (p_addr) else $error("external address wrong");
   property p_odd; !ext_bhe_b && ext_ble_b && !ext_rd_b |-> ext_addr[0]; endproperty
   a_odd: assert property (p_odd) else $error("high lane byte at even address");
   property p_split;
      $rose(ext_rd_b) && core_req.word && !ext_addr[0] && narrow_low_cnt_r >= 4'h8 |-> ##[1:8] $fell(ext_rd_b);
   endproperty
   a_split: assert property (p_split) else $error("odd byte cycle missing");
   property p_psel; periph_sel |-> (periph_addr == core_req.addr[15:0]) ##1 !periph_sel; endproperty
   a_psel: assert property (p_psel) else $error("peripheral select wrong");
   property p_wide; wide_internal_memory_bus.valid |-> wide_internal_memory_bus.addr == core_req.addr; endproperty
   a_wide: assert property (p_wide) else $error("wide bus address wrong");
   cover property ($fell(ext_wr_b));
   cover property (!ext_bhe_b && ext_ble_b && !ext_rd_b);
   cover property (periph_sel);
endmodule
bind ebi_bus_unit ebi_chk u_chk (.clk, .rst_b, .core_req, .ext_addr, .ext_data_oe_b, .ext_wr_dir, .ext_rd_b,
   .ext_wr_b, .ext_ble_b, .ext_bhe_b, .wide_internal_memory_bus, .periph_addr, .periph_sel, .narrow_bus_size_n);

// File: bench/ebi_mem.sv
// Purpose: Static RAM or 8-bit device on the external bus.
// Assumes: Strobes and byte enables are active low.
// Notes:   Released data lines show the inverse of the last value.
`timescale 1ns/100ps
module ebi_mem (
   input  wire logic        clk,
   input  wire logic [25:0] ext_addr,
   input  wire logic [15:0] ext_data_o,
   input  wire logic        ext_rd_b,
   input  wire logic        ext_wr_b,
   input  wire logic        ext_ble_b,
   input  wire logic        ext_bhe_b,
   output logic      [15:0] ext_data_i
);
   logic [15:0] mem [256];
   logic [15:0] last_q = 16'h0000;
   // Released lines show the inverse of the last value read.
   always @(*) ext_data_i = !ext_rd_b ? mem[ext_addr[8:1]] : ~last_q;
   // Written bytes follow the active-low lane enables.
   always @(posedge clk) begin
      if (!ext_rd_b) last_q <= mem[ext_addr[8:1]];
      if (!ext_wr_b && !ext_ble_b) mem[ext_addr[8:1]][7:0] <= ext_data_o[7:0];
      if (!ext_wr_b && !ext_bhe_b) mem[ext_addr[8:1]][15:8] <= ext_data_o[15:8];
   end
endmodule

// File: bench/testbench.sv
// Purpose: Self-checking bench for the bus unit.
// Assumes: Inputs change at the falling clock edge.
// Notes:   The clock is halted once to show that state survives.
`timescale 1ns/100ps
module testbench;
   import ebi_pkg::*;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        run = 1'b1;
   logic        narrow_bus_size_n = 1'b1;
   ebi_req_t    req = '0;
   ebi_rsp_t    rsp;
   ebi_req_t    wide;
   logic [25:0] ext_addr;
   logic [15:0] ext_data_o, periph_addr, periph_wdata, rd;
   logic [15:0] ext_data_i;
   logic        ext_data_oe_b, ext_wr_dir, ext_rd_b, ext_wr_b, ext_ble_b, ext_bhe_b, periph_sel, periph_write;
   int          num_errors = 0, cmp_count = 0, n_rd = 0, n_sel = 0;
   initial forever #5 clk = run ? ~clk : clk;
   ebi_bus_unit dut (.clk, .rst_b, .core_req(req), .core_rsp(rsp), .ext_addr, .ext_data_o, .ext_data_oe_b,
      .ext_data_i, .ext_wr_dir, .ext_rd_b, .ext_wr_b, .ext_ble_b, .ext_bhe_b, .narrow_bus_size_n,
      .wide_internal_memory_bus(wide), .wide_rdata(16'h0000), .periph_addr, .periph_wdata, .periph_sel,
      .periph_write, .periph_rdata(16'h5AC3));
   ebi_mem u_mem (.clk, .ext_addr, .ext_data_o, .ext_rd_b, .ext_wr_b, .ext_ble_b, .ext_bhe_b, .ext_data_i);
   always @(posedge clk) begin
      if (periph_sel === 1'b1) n_sel++;
   end
   always @(negedge ext_rd_b) n_rd++;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic op(input logic w, input logic wd, input logic io, input logic [25:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge clk);
      req = '{1'b1, w, wd, io, a, d};
      do begin
         @(negedge clk);
         n++;
      end while (rsp.done !== 1'b1 && n < 50);
      rd = rsp.rdata;
      req.valid = 1'b0;
      if (n >= 50) num_errors++;
   endtask
   task automatic t_wide();
      op(1'b1, 1'b1, 1'b0, 26'h2ABCDE, 16'hBEEF);
      op(1'b1, 1'b0, 1'b0, 26'h2ABCDF, 16'h1200);
      n_rd = 0;
      op(1'b0, 1'b1, 1'b0, 26'h2ABCDE, 16'h0000);
      chk(rd, 16'h12EF);
      chk(n_rd, 1);
      chk(wide.addr, 26'h2ABCDE);
      $display("wide test done");
   endtask
   task automatic t_narrow();
      narrow_bus_size_n = 1'b0;
      repeat (4) @(negedge clk);
      op(1'b1, 1'b1, 1'b0, 26'h3ABC10, 16'hC0DE);
      run = 1'b0;
      #200;
      run = 1'b1;
      n_rd = 0;
      op(1'b0, 1'b1, 1'b0, 26'h3ABC10, 16'h0000);
      chk(rd, 16'hC0DE);
      chk(n_rd, 2);
      narrow_bus_size_n = 1'b1;
      $display("narrow test done");
   endtask
   task automatic t_periph();
      n_sel = 0;
      op(1'b0, 1'b1, 1'b1, 26'h0000010, 16'h0000);
      chk(rd, 16'h5AC3);
      op(1'b1, 1'b1, 1'b1, 26'h000F802, 16'h7E57);
      chk(periph_wdata, 16'h7E57);
      chk(periph_write, 1'b1);
      op(1'b0, 1'b1, 1'b0, 26'h3FF0004, 16'h0000);
      op(1'b0, 1'b1, 1'b1, 26'h0000500, 16'h0000);
      chk(n_sel, 3);
      $display("peripheral test done");
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      t_wide();
      t_narrow();
      t_periph();
      tally_and_finish();
   end
   initial begin
      #20000;
      num_errors++;
      tally_and_finish();
   end
endmodule
